// >>> acc_pkg.sv
// Package with constants, register map and types of the converter control block.
package acc_pkg;

	// ==========================================================
	// Register map (byte addresses).
	localparam logic [7:0] ACC_OFF_CHANNEL = 8'h00;
	localparam logic [7:0] ACC_OFF_REF     = 8'h04;
	localparam logic [7:0] ACC_OFF_CLKDIV  = 8'h08;
	localparam logic [7:0] ACC_OFF_CTRL    = 8'h0C;
	localparam logic [7:0] ACC_OFF_RESULT  = 8'h10;
	localparam logic [7:0] ACC_OFF_STATUS  = 8'h14;

	// ==========================================================
	// Field layout.
	localparam int ACC_CH_W      = 6;
	localparam int ACC_DIV_W     = 6;
	localparam int ACC_RES_W     = 10;
	localparam int CTRL_START_B  = 0;
	localparam int CTRL_CSRC_B   = 1;
	localparam int REF_NEG_B     = 2;
	localparam int STAT_BUSY_B   = 0;
	localparam int STAT_DONE_B   = 1;
	localparam int STAT_DCLR_B   = 1;

	// ==========================================================
	// Channel codes: ports A, B, C then internal sources.
	localparam logic [5:0] ACC_CH_PORTA = 6'h00;
	localparam logic [5:0] ACC_CH_PORTB = 6'h08;
	localparam logic [5:0] ACC_CH_PORTC = 6'h10;
	localparam logic [5:0] ACC_CH_TEMP  = 6'h3B;
	localparam logic [5:0] ACC_CH_DAC   = 6'h3C;
	localparam logic [5:0] ACC_CH_FIXED = 6'h3D;
	localparam logic [5:0] ACC_CH_GND   = 6'h3E;

	// ==========================================================
	// Conversion timing: 11.5 periods counted in half periods.
	localparam logic [4:0] ACC_HALF_PERIODS = 5'h17;
	localparam logic [1:0] ACC_RC_STAGES    = 2'h2;

	// Reference select encodings.
	typedef enum logic [1:0] {
		ACC_PREF_VDD  = 2'b00,
		ACC_PREF_PIN  = 2'b10,
		ACC_PREF_FIXD = 2'b11
	} acc_pref_e;

	// Routing presented to the analog side.
	typedef struct packed {
		logic [23:0] pinSel;
		logic        tempSel;
		logic        dacSel;
		logic        fixedSel;
		logic        gndSel;
	} acc_route_s;

	// Control fields set by software.
	typedef struct packed {
		logic [5:0] channel;
		logic [1:0] posRef;
		logic       negRef;
		logic [5:0] clkDiv;
		logic       clkSrc;
	} acc_cfg_s;

endpackage : acc_pkg

// >>> acc_clkgen.sv
// Conversion clock generator: divided system clock or dedicated RC tick.
`timescale 1ns/1ps
`default_nettype none
module acc_clkgen
	import acc_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic [ACC_DIV_W-1:0] clkDiv,
	input  wire logic                 clkSrc,
	input  wire logic                 rcTick,
	output logic                      halfTick
);
	import acc_pkg::*;

	typedef struct packed {
		logic [ACC_DIV_W-1:0] cnt;
		logic [1:0]           rcSync;
		logic                 rcPrev;
		logic                 tick;
	} acc_cg_s;

	acc_cg_s st_r;
	acc_cg_s st_nxt;

	// ==========================================================
	// Each half period lasts clkDiv+1 system clocks, so the full period
	// is the system clock divided by 2,4,..128; the RC tick is synchronised.
	always_comb begin
		st_nxt = st_r;
		st_nxt.rcSync = {st_r.rcSync[0], rcTick};
		st_nxt.rcPrev = st_r.rcSync[1];
		st_nxt.tick = 1'b0;
		if (clkSrc) begin
			st_nxt.tick = st_r.rcSync[1] & ~st_r.rcPrev;
			st_nxt.cnt = '0;
		end else if (st_r.cnt >= clkDiv) begin
			st_nxt.cnt = '0;
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign halfTick = st_r.tick;

	chk_div_tick: assert property (@(posedge clk) disable iff (!rstn)
		(!clkSrc && !$past(clkSrc) && st_r.cnt == '0 && clkDiv == '0 && $past(clkDiv) == '0)
		|=> halfTick) else $error("divided tick missing");
endmodule // acc_clkgen
`default_nettype wire

// >>> acc_top.sv
// Converter configuration and control block with an AXI4-Lite register slave.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module acc_top
	import acc_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic [7:0]           awaddr,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	input  wire logic                 wvalid,
	output logic                      wready,
	output logic [1:0]                bresp,
	output logic                      bvalid,
	input  wire logic                 bready,
	input  wire logic [7:0]           araddr,
	input  wire logic                 arvalid,
	output logic                      arready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	output logic                      rvalid,
	input  wire logic                 rready,
	input  wire logic                 rcTick,
	input  wire logic                 cmpIn,
	output acc_pkg::acc_route_s       route,
	output acc_pkg::acc_pref_e        posRefSel,
	output logic                      fixedLevel,
	output logic [1:0]                fixedRange,
	output logic                      negRefSel,
	output logic                      sampleHold
);
	import acc_pkg::*;

	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_CONV = 2'b01,
		ACC_DONE = 2'b10
	} acc_state_e;

	typedef struct packed {
		acc_cfg_s             cfg;
		logic [1:0]           fixRange;
		acc_state_e           fsm;
		logic [4:0]           halfCnt;
		logic [ACC_RES_W-1:0] sar;
		logic [ACC_RES_W-1:0] result;
		logic                 done;
		logic                 startReq;
		logic [1:0]           rcDelay;
		logic                 awHeld;
		logic                 wHeld;
		logic [7:0]           awAddr;
		logic [31:0]          wData;
		logic                 bValid;
		logic [1:0]           bResp;
		logic                 rValid;
		logic [31:0]          rData;
		logic [1:0]           rResp;
	} acc_st_s;

	acc_st_s st_r;
	acc_st_s st_nxt;
	logic    halfTick;

	// Decodes whether a byte address is a mapped register.
	function automatic logic accMapped(input logic [7:0] a);
		accMapped = (a == ACC_OFF_CHANNEL) || (a == ACC_OFF_REF) || (a == ACC_OFF_CLKDIV)
			|| (a == ACC_OFF_CTRL) || (a == ACC_OFF_RESULT) || (a == ACC_OFF_STATUS);
	endfunction

	// ==========================================================
	// Conversion clock.
	acc_clkgen u_clkgen (
		.clk      (clk),
		.rstn     (rstn),
		.clkDiv   (st_r.cfg.clkDiv),
		.clkSrc   (st_r.cfg.clkSrc),
		.rcTick   (rcTick),
		.halfTick (halfTick)
	);

	// ==========================================================
	// Bus slave, configuration and conversion sequencer in one next-state process.
	always_comb begin
		st_nxt = st_r;
		if (awvalid && !st_r.awHeld && !st_r.bValid) begin
			st_nxt.awHeld = 1'b1;
			st_nxt.awAddr = awaddr;
		end
		if (wvalid && !st_r.wHeld && !st_r.bValid) begin
			st_nxt.wHeld = 1'b1;
			st_nxt.wData = wdata;
		end
		if (st_r.bValid && bready) begin
			st_nxt.bValid = 1'b0;
		end
		if (st_r.rValid && rready) begin
			st_nxt.rValid = 1'b0;
		end
		// In RC mode a start waits extra clocks before the sequencer sees it.
		if (st_r.rcDelay != 2'b00) begin
			st_nxt.rcDelay = st_r.rcDelay - 2'b01;
		end
		// Both halves held: perform the write. Strobes are ignored; each write replaces the word.
		if (st_r.awHeld && st_r.wHeld) begin
			st_nxt.awHeld = 1'b0;
			st_nxt.wHeld = 1'b0;
			st_nxt.bValid = 1'b1;
			st_nxt.bResp = accMapped(st_r.awAddr) ? 2'b00 : 2'b10;
			if (st_r.awAddr == ACC_OFF_CHANNEL) begin
				st_nxt.cfg.channel = st_r.wData[ACC_CH_W-1:0];
			end
			if (st_r.awAddr == ACC_OFF_REF) begin
				st_nxt.cfg.posRef = st_r.wData[1:0];
				st_nxt.cfg.negRef = st_r.wData[REF_NEG_B];
				st_nxt.fixRange = st_r.wData[5:4];
			end
			if (st_r.awAddr == ACC_OFF_CLKDIV) begin
				st_nxt.cfg.clkDiv = st_r.wData[ACC_DIV_W-1:0];
			end
			if (st_r.awAddr == ACC_OFF_CTRL) begin
				st_nxt.cfg.clkSrc = st_r.wData[CTRL_CSRC_B];
				if (st_r.wData[CTRL_START_B] && st_r.fsm == ACC_IDLE) begin
					st_nxt.startReq = 1'b1;
					st_nxt.rcDelay = st_r.wData[CTRL_CSRC_B] ? ACC_RC_STAGES : 2'b00;
				end
			end
		end
		// Register reads; busy also covers a start still waiting for its first half tick,
		// so software never sees neither busy nor done after it has started a conversion.
		if (arvalid && !st_r.rValid) begin
			st_nxt.rValid = 1'b1;
			st_nxt.rResp = accMapped(araddr) ? 2'b00 : 2'b10;
			st_nxt.rData = '0;
			unique case (araddr)
				ACC_OFF_CHANNEL: st_nxt.rData[ACC_CH_W-1:0] = st_r.cfg.channel;
				ACC_OFF_REF:     st_nxt.rData[5:0] = {st_r.fixRange, 1'b0, st_r.cfg.negRef,
					st_r.cfg.posRef};
				ACC_OFF_CLKDIV:  st_nxt.rData[ACC_DIV_W-1:0] = st_r.cfg.clkDiv;
				ACC_OFF_CTRL:    st_nxt.rData[CTRL_CSRC_B] = st_r.cfg.clkSrc;
				ACC_OFF_RESULT:  st_nxt.rData[ACC_RES_W-1:0] = st_r.result;
				ACC_OFF_STATUS:  st_nxt.rData[1:0] = {st_r.done,
					(st_r.fsm != ACC_IDLE) || st_r.startReq};
				default:         st_nxt.rData = '0;
			endcase
		end
		// Sequencer: each half tick is half a bit period.
		unique case (st_r.fsm)
			ACC_IDLE: begin
				if (st_r.startReq && st_r.rcDelay == 2'b00 && halfTick) begin
					st_nxt.startReq = 1'b0;
					st_nxt.fsm = ACC_CONV;
					st_nxt.halfCnt = '0;
					st_nxt.sar = '0;
					st_nxt.done = 1'b0;
				end
			end
			ACC_CONV: begin
				if (halfTick) begin
					st_nxt.halfCnt = st_r.halfCnt + 5'h01;
					// Bits are decided MSB first on odd half periods after sampling.
					if (st_r.halfCnt[0] && st_r.halfCnt < (ACC_HALF_PERIODS - 5'h02)) begin
						st_nxt.sar = {st_r.sar[ACC_RES_W-2:0], cmpIn};
					end
					if (st_r.halfCnt == ACC_HALF_PERIODS - 5'h01) begin
						st_nxt.fsm = ACC_DONE;
					end
				end
			end
			ACC_DONE: begin
				st_nxt.result = st_r.sar;
				st_nxt.done = 1'b1;
				st_nxt.fsm = ACC_IDLE;
			end
			default: st_nxt.fsm = ACC_IDLE;
		endcase
		// Software clear of done; a completion in the same cycle wins.
		if (st_r.awHeld && st_r.wHeld && st_r.awAddr == ACC_OFF_STATUS
			&& st_r.wData[STAT_DCLR_B] && st_r.fsm != ACC_DONE) begin
			st_nxt.done = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// Outputs: one-hot routing decoded from the channel code.
	always_comb begin
		route = '0;
		if (st_r.cfg.channel < 6'h18) begin
			route.pinSel[st_r.cfg.channel[4:0]] = 1'b1;
		end
		route.tempSel  = (st_r.cfg.channel == ACC_CH_TEMP);
		route.dacSel   = (st_r.cfg.channel == ACC_CH_DAC);
		route.fixedSel = (st_r.cfg.channel == ACC_CH_FIXED);
		route.gndSel   = (st_r.cfg.channel == ACC_CH_GND);
	end

	assign posRefSel  = (st_r.cfg.posRef == 2'b01) ? ACC_PREF_VDD : acc_pref_e'(st_r.cfg.posRef);
	assign fixedLevel = (st_r.cfg.posRef == ACC_PREF_FIXD);
	assign fixedRange = st_r.fixRange;
	assign negRefSel  = st_r.cfg.negRef;
	assign sampleHold = (st_r.fsm == ACC_CONV) && (st_r.halfCnt < 5'h02);
	assign awready = awvalid && !st_r.awHeld && !st_r.bValid;
	assign wready  = wvalid && !st_r.wHeld && !st_r.bValid;
	assign bvalid  = st_r.bValid;
	assign bresp   = st_r.bResp;
	assign arready = arvalid && !st_r.rValid;
	assign rvalid  = st_r.rValid;
	assign rdata   = st_r.rData;
	assign rresp   = st_r.rResp;

	// ==========================================================
	// Checks.
	chk_route_onehot: assert property (@(posedge clk) disable iff (!rstn)
		$countones(route) <= 1) else $error("more than one source routed");
	chk_gnd_route: assert property (@(posedge clk) disable iff (!rstn)
		(st_r.cfg.channel == ACC_CH_GND) |-> route.gndSel) else $error("ground not routed");
	chk_conv_len: assert property (@(posedge clk) disable iff (!rstn)
		(st_r.fsm == ACC_CONV && halfTick && st_r.halfCnt == ACC_HALF_PERIODS - 5'h01)
		|=> st_r.fsm == ACC_DONE) else $error("conversion length wrong");
	chk_done_flag: assert property (@(posedge clk) disable iff (!rstn)
		(st_r.fsm == ACC_DONE) |=> (st_r.done && st_r.result == $past(st_r.sar)))
		else $error("result not presented");
	chk_neg_ref: assert property (@(posedge clk) disable iff (!rstn)
		(st_r.awHeld && st_r.wHeld && st_r.awAddr == ACC_OFF_REF)
		|=> negRefSel == $past(st_r.wData[REF_NEG_B])) else $error("negative reference mismatch");
	chk_pos_ref: assert property (@(posedge clk) disable iff (!rstn)
		(st_r.cfg.posRef == 2'b11) |-> fixedLevel) else $error("fixed reference not picked");
	chk_rc_delay: assert property (@(posedge clk) disable iff (!rstn)
		(st_r.rcDelay != 2'b00) |-> st_r.fsm != ACC_CONV) else $error("rc start too early");
	chk_bresp_hold: assert property (@(posedge clk) disable iff (!rstn)
		(bvalid && !bready) |=> bvalid) else $error("write response dropped");
	cov_conv: cover property (@(posedge clk) st_r.fsm == ACC_DONE);
	cov_rc: cover property (@(posedge clk) st_r.cfg.clkSrc && st_r.fsm == ACC_CONV);
	cov_err: cover property (@(posedge clk) bvalid && bresp == 2'b10);
endmodule // acc_top
`default_nettype wire

// >>> acc_analog_model.sv
// Behavioural model of the analog sources and RC oscillator facing the block.
`timescale 1ns/1ps
`default_nettype none
module acc_analog_model
	import acc_pkg::*;
(
	input  wire logic               clk,
	input  wire acc_pkg::acc_route_s route,
	output logic                    cmpIn,
	output logic                    rcTick
);
	import acc_pkg::*;
	logic toggle = 1'b0;
	// ==========================================
	// Free RC oscillator: a rising edge every 200 ns marks one converter half period.
	initial begin
		rcTick = 1'b0;
		#7;
		forever #100 rcTick = ~rcTick;
	end
	// Every pin is taken as configured analog and sits at full scale, ground at zero;
	// the internal sources show a toggling level.
	always @(posedge clk) begin
		toggle <= ~toggle;
	end
	assign cmpIn = route.gndSel ? 1'b0 : (|route.pinSel ? 1'b1 : toggle);
endmodule // acc_analog_model
`default_nettype wire

// >>> acc_top_tb_top.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
`default_nettype none
module acc_top_tb_top;
	import acc_pkg::*;
	// ==========================================
	// Clock, reset, bus and observed signals.
	logic clk = 1'b0, rstn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	wire logic awready, wready, bvalid, arready, rvalid, rcTick, cmpIn;
	wire logic fixedLevel, negRefSel, sampleHold;
	wire logic [1:0] bresp, rresp, fixedRange;
	wire logic [31:0] rdata;
	wire acc_route_s route;
	wire acc_pref_e posRefSel;
	int nMismatch = 0, nCompared = 0, shCnt = 0, rdiv, rpin;
	logic [31:0] rd;
	logic [1:0] rs;
	always #12.5 clk = ~clk;
	// Hold-phase length is counted here so the task can judge it afterwards.
	always @(posedge clk) if (sampleHold === 1'b1) shCnt <= shCnt + 1;
	acc_top acc_top_i (.clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.rcTick(rcTick), .cmpIn(cmpIn), .route(route), .posRefSel(posRefSel),
		.fixedLevel(fixedLevel), .fixedRange(fixedRange), .negRefSel(negRefSel),
		.sampleHold(sampleHold));
	acc_analog_model acc_analog_model_i (.clk(clk), .route(route), .cmpIn(cmpIn),
		.rcTick(rcTick));
	// ==========================================
	// Reporting and closing.
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			nMismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", nCompared, nMismatch);
		if (nMismatch == 0 && nCompared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ==========================================
	// Bus tasks; each channel is dropped at the edge where it is taken.
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
	endtask
	task automatic axr(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask
	// Reference routing computed from the channel code alone.
	function automatic acc_route_s expRoute(input int c);
		acc_route_s e;
		e = '0;
		if (c < 24) e.pinSel[c] = 1'b1;
		else if (c == ACC_CH_TEMP) e.tempSel = 1'b1;
		else if (c == ACC_CH_DAC) e.dacSel = 1'b1;
		else if (c == ACC_CH_FIXED) e.fixedSel = 1'b1;
		else if (c == ACC_CH_GND) e.gndSel = 1'b1;
		return e;
	endfunction
	// One conversion; the window allows for poll granularity after the last tick.
	task automatic conv(input int div, input logic src, input int ch, input int lo,
		input int hi, input logic [9:0] er);
		realtime t0;
		int cyc, t;
		axw(ACC_OFF_CLKDIV, 32'(div));
		axw(ACC_OFF_CHANNEL, 32'(ch));
		repeat (20) @(posedge clk);
		shCnt = 0;
		axw(ACC_OFF_CTRL, 32'({src, 1'b1}));
		t0 = $realtime;
		t = 0;
		do begin
			axr(ACC_OFF_STATUS);
			t++;
			if (t == 1) chk("busy", 32'(rd[STAT_BUSY_B]), 1);
		end while (rd[STAT_DONE_B] !== 1'b1);
		cyc = int'(($realtime - t0) / 25.0);
		chk("convCycles", 32'(cyc >= lo && cyc <= hi), 1);
		if (!src) chk("holdCycles", 32'(shCnt >= 2*div+1 && shCnt <= 2*div+3), 1);
		axr(ACC_OFF_RESULT);
		chk("result", rd, 32'(er));
		axw(ACC_OFF_STATUS, 32'h2);
		axr(ACC_OFF_STATUS);
		chk("doneClear", 32'(rd[STAT_DONE_B]), 0);
	endtask
	// ==========================================
	// Watchdog sized well above the expected run of a few thousand cycles.
	initial begin
		#(25 * 40000);
		nMismatch++;
		end_of_test();
	end
	// ==========================================
	// Main sequence.
	initial begin
		int q[$];
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		void'($urandom(61));
		rdiv = $urandom_range(62, 1);
		rpin = $urandom_range(23, 0);
		// Reset values and unmapped place.
		axr(ACC_OFF_CHANNEL);
		chk("chanReset", rd, 0);
		axr(ACC_OFF_STATUS);
		chk("statReset", rd, 0);
		axr(8'h18);
		chk("rdUnmapped", {rd[29:0], rs}, 32'h2);
		axw(8'h1C, 32'h5);
		chk("wrUnmapped", 32'(rs), 32'h2);
		$display("test reset done");
		// Every source code, plus one unmapped code that must route nothing.
		for (int c = 0; c < 24; c++) q.push_back(c);
		q.push_back(ACC_CH_TEMP);
		q.push_back(ACC_CH_DAC);
		q.push_back(ACC_CH_FIXED);
		q.push_back(ACC_CH_GND);
		q.push_back($urandom_range(58, 24));
		foreach (q[i]) begin
			axw(ACC_OFF_CHANNEL, 32'(q[i]));
			chk("wrResp", 32'(rs), 32'h0);
			chk("route", 32'(route), 32'(expRoute(q[i])));
			axr(ACC_OFF_CHANNEL);
			chk("chanRead", rd, 32'(q[i]));
			chk("rdResp", 32'(rs), 32'h0);
		end
		$display("test channels done");
		// All reference field combinations.
		for (int i = 0; i < 32; i++) begin
			axw(ACC_OFF_REF, 32'({i[4:3], 1'b0, i[2], i[1:0]}));
			chk("posRef", 32'(posRefSel), (i[1:0] == 2'b01) ? 0 : 32'(i[1:0]));
			chk("fixedSel", {fixedLevel, fixedRange}, {i[1:0] == 2'b11, i[4:3]});
			chk("negRef", 32'(negRefSel), 32'(i[2]));
		end
		$display("test references done");
		// Divider extremes, a random divider and the RC clock.
		conv(0, 1'b0, rpin, 23, 34, 10'h3FF);
		conv(63, 1'b0, ACC_CH_GND, 23*64, 24*64+10, 10'h000);
		conv(rdiv, 1'b0, rpin, 23*(rdiv+1), 24*(rdiv+1)+10, 10'h3FF);
		axw(ACC_OFF_CHANNEL, 32'(ACC_CH_GND));
		conv(rdiv, 1'b1, ACC_CH_GND, 23*8, 24*8+14, 10'h000);
		$display("test conversions done");
		// Reset in mid-run clears the configuration.
		axw(ACC_OFF_CHANNEL, 32'h5);
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		chk("routeReset", 32'(route), 32'(expRoute(0)));
		rstn <= 1'b1;
		axr(ACC_OFF_CHANNEL);
		chk("chanReset2", rd, 0);
		$display("test second reset done");
		end_of_test();
	end
endmodule // acc_top_tb_top
`default_nettype wire
